// >>> include/ecp_params.svh
`ifndef ECP_PARAMS_SVH
`define ECP_PARAMS_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ECP_OFS_CFGB 11'h401
`define ECP_OFS_ECR 11'h402
`define ECP_OFS_IDX 11'h403
`define ECP_OFS_DATA 11'h404
`define ECP_OFS_AUX 11'h405
`define ECP_SL_CTL0 3'h0
`define ECP_SL_CTL2 3'h2
`define ECP_SL_CTL4 3'h4
`define ECP_SL_SETUP 3'h5
// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define ECP_ECR_SVC 2
`define ECP_ECR_DMA 3
`define ECP_ECR_MASK 4
`define ECP_C0_TOMASK 0
`define ECP_C0_FREEZE 4
`define ECP_ECR_RST 8'h15
`define ECP_CTL0_RST 8'h00
`define ECP_CTL2_RST 8'h00
`define ECP_CTL4_RST 8'h07
`define ECP_SETUP_RST 8'h00
`define ECP_THRESH 5'h08
`endif

// >>> include/ecp_pkg.sv
`default_nettype none
package ecp_pkg;
    typedef enum logic [2:0] {
        ECP_MODE_STD = 3'h0,
        ECP_MODE_BYTE = 3'h1,
        ECP_MODE_PFIFO = 3'h2,
        ECP_MODE_EFIFO = 3'h3,
        ECP_MODE_EPP = 3'h4,
        ECP_MODE_RSVD = 3'h5,
        ECP_MODE_TEST = 3'h6,
        ECP_MODE_CFG = 3'h7
    } ecp_mode_e;
    typedef enum logic [0:0] {
        ECP_ST_IDLE = 1'h0,
        ECP_ST_WAIT = 1'h1
    } ecp_state_e;
    typedef struct packed {
        logic rd;
        logic wr;
        logic [10:0] addr;
        logic [7:0] wdata;
    } ecp_host_req_s;
    typedef struct packed {
        logic empty;
        logic full;
        logic [4:0] free_cnt;
        logic [4:0] fill_cnt;
        logic bottom_tag;
        logic stale;
    } ecp_fifo_stat_s;
endpackage
`default_nettype wire

// >>> rtl/ecp_ext_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "ecp_params.svh"
module ecp_ext_regs (
    input wire logic mclk,
    input wire logic reset,
    input wire ecp_pkg::ecp_host_req_s host_req,
    output logic host_ready,
    output logic iochrdy,
    output logic rd_valid,
    output logic [7:0] rd_data,
    input wire logic rd_ready,
    input wire ecp_pkg::ecp_fifo_stat_s fifo_stat,
    input wire logic clk_frozen,
    input wire logic line_dir,
    input wire logic ext_enable,
    input wire logic dma_req_in,
    input wire logic epp_timeout,
    input wire logic err_n_pin,
    input wire logic irq_line_pin,
    input wire logic tc_pin,
    input wire logic dack_n_pin,
    output logic irq_pulse,
    output logic [2:0] mode,
    output logic dma_enable,
    output logic drq_out,
    output logic drq_oe_n,
    output logic dack_active,
    output logic freeze,
    output logic freeze_init,
    output logic [7:0] control2,
    output logic [7:0] control4,
    output logic [7:0] port_dma_irq_setup
);
    import ecp_pkg::*;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    localparam int NSYNC = 4;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] meta_r;
    logic [NSYNC-1:0] sync_r;
    logic [NSYNC-1:0] sync_d_r;
    assign pin_raw = {dack_n_pin, tc_pin, irq_line_pin, err_n_pin};

    // two flops per pin, then one delay stage for edge detection
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            meta_r <= 4'hD;
            sync_r <= 4'hD;
            sync_d_r <= 4'hD;
        end
        else
        begin
            meta_r <= pin_raw;
            sync_r <= meta_r;
            sync_d_r <= sync_r;
        end
    end

    logic err_n_s;
    logic err_n_d;
    logic irq_s;
    logic tc_rise;
    logic dack_s;
    assign err_n_s = sync_r[0];
    assign err_n_d = sync_d_r[0];
    assign irq_s = sync_r[1];
    assign tc_rise = sync_r[2] & ~sync_d_r[2];
    assign dack_s = ~sync_r[3];

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [7:0] ecr_r, ecr_nxt;
    logic [2:0] idx_r, idx_nxt;
    logic [7:0] ctl0_r, ctl0_nxt;
    logic [7:0] ctl2_r, ctl2_nxt;
    logic [7:0] ctl4_r, ctl4_nxt;
    logic [7:0] setup_r, setup_nxt;
    logic irq_r, irq_nxt;
    logic freeze_r, freeze_nxt;
    logic finit_r, finit_nxt;
    logic drq_r, drq_nxt;
    logic drq_oe_n_r, drq_oe_n_nxt;
    logic dack_r, dack_nxt;
    ecp_state_e state_r, state_nxt;
    logic [7:0] rdata_comb;
    logic acc_rd, acc_wr, push;
    logic hw_set, ev_err, ev_to;
    ecp_host_req_s held_r, held_nxt;
    ecp_host_req_s cur;

    // request seen this cycle, or the one parked for a stale read
    assign cur = (state_r == ECP_ST_WAIT) ? held_r : host_req;
    assign acc_wr = (state_r == ECP_ST_IDLE) & host_ready & host_req.wr;
    assign acc_rd = (state_r == ECP_ST_IDLE) & host_ready & host_req.rd;

    // read data mux
    always_comb
    begin
        rdata_comb = 8'h00;
        if (cur.addr == `ECP_OFS_CFGB)
        begin
            // mirror of setup bits, mode 111 only
            if (ecr_r[7:5] == ECP_MODE_CFG)
                rdata_comb = {1'b0, irq_s, setup_r[5:3], 1'b0, setup_r[1:0]};
        end
        else if (cur.addr == `ECP_OFS_ECR)
        begin
            // frozen clock forces flags on, service off
            rdata_comb = {ecr_r[7:3], ecr_r[2] & ~clk_frozen,
                          fifo_stat.full | clk_frozen, fifo_stat.empty | clk_frozen};
        end
        else if (cur.addr == `ECP_OFS_IDX)
        begin
            if (ext_enable)
                rdata_comb = {5'h00, idx_r};
        end
        else if (cur.addr == `ECP_OFS_DATA)
        begin
            if (ext_enable)
            begin
                if (idx_r == `ECP_SL_CTL0)
                    rdata_comb = ctl0_r;
                else if (idx_r == `ECP_SL_CTL2)
                    rdata_comb = ctl2_r;
                else if (idx_r == `ECP_SL_CTL4)
                    rdata_comb = ctl4_r;
                else if (idx_r == `ECP_SL_SETUP)
                    rdata_comb = setup_r;
            end
        end
        else if (cur.addr == `ECP_OFS_AUX)
        begin
            // bottom tag in backward mode 011, else zero
            if (ecr_r[7:5] == ECP_MODE_EFIFO && line_dir)
                rdata_comb = {fifo_stat.bottom_tag, 7'h00};
        end
    end

    // ----------------------------------------------------------------
    // control and event logic
    // ----------------------------------------------------------------
    always_comb
    begin
        ecr_nxt = ecr_r;
        idx_nxt = idx_r;
        ctl0_nxt = ctl0_r;
        ctl2_nxt = ctl2_r;
        ctl4_nxt = ctl4_r;
        setup_nxt = setup_r;
        if (acc_wr)
        begin
            if (host_req.addr == `ECP_OFS_ECR)
                ecr_nxt[7:2] = host_req.wdata[7:2];
            else if (host_req.addr == `ECP_OFS_IDX && ext_enable)
                idx_nxt = host_req.wdata[2:0];
            else if (host_req.addr == `ECP_OFS_DATA && ext_enable)
            begin
                // write lands in selected register only
                if (idx_r == `ECP_SL_CTL0)
                    ctl0_nxt = host_req.wdata;
                else if (idx_r == `ECP_SL_CTL2)
                    ctl2_nxt = host_req.wdata;
                else if (idx_r == `ECP_SL_CTL4)
                    ctl4_nxt = host_req.wdata;
                else if (idx_r == `ECP_SL_SETUP)
                    setup_nxt = host_req.wdata;
            end
            // writes to the mirror fall through untouched
        end
        // armed events by DMA state and direction
        hw_set = ~ecr_r[`ECP_ECR_SVC] & (ecr_r[`ECP_ECR_DMA] ? tc_rise :
                 (line_dir ? (fifo_stat.fill_cnt >= `ECP_THRESH) : (fifo_stat.free_cnt >= `ECP_THRESH)));
        // hardware set wins over a software clear
        if (hw_set)
            ecr_nxt[`ECP_ECR_SVC] = 1'b1;
        // error falling edge, or unmask with error low
        ev_err = ~ecr_nxt[`ECP_ECR_MASK] & ((err_n_d & ~err_n_s) |
                 (ecr_r[`ECP_ECR_MASK] & ~err_n_s));
        ev_to = epp_timeout & ctl0_r[`ECP_C0_TOMASK];
        irq_nxt = hw_set | ev_err | ev_to;
        // freeze in mode 011, release pulses init
        freeze_nxt = (ecr_nxt[7:5] == ECP_MODE_EFIFO) & ctl0_nxt[`ECP_C0_FREEZE];
        finit_nxt = (ecr_r[7:5] == ECP_MODE_EFIFO) & ctl0_r[`ECP_C0_FREEZE] & ~ctl0_nxt[`ECP_C0_FREEZE];
        // request floats and acknowledge ignored with DMA off
        drq_oe_n_nxt = ~ecr_nxt[`ECP_ECR_DMA];
        drq_nxt = dma_req_in & ecr_nxt[`ECP_ECR_DMA] & ~ecr_nxt[`ECP_ECR_SVC];
        dack_nxt = dack_s & ecr_nxt[`ECP_ECR_DMA];
    end

    // register stage for control state
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            ecr_r <= `ECP_ECR_RST;
            idx_r <= 3'h0;
            ctl0_r <= `ECP_CTL0_RST;
            ctl2_r <= `ECP_CTL2_RST;
            ctl4_r <= `ECP_CTL4_RST;
            setup_r <= `ECP_SETUP_RST;
            irq_r <= 1'b0;
            freeze_r <= 1'b0;
            finit_r <= 1'b0;
            drq_r <= 1'b0;
            drq_oe_n_r <= 1'b1;
            dack_r <= 1'b0;
        end
        else
        begin
            ecr_r <= ecr_nxt;
            idx_r <= idx_nxt;
            ctl0_r <= ctl0_nxt;
            ctl2_r <= ctl2_nxt;
            ctl4_r <= ctl4_nxt;
            setup_r <= setup_nxt;
            irq_r <= irq_nxt;
            freeze_r <= freeze_nxt;
            finit_r <= finit_nxt;
            drq_r <= drq_nxt;
            drq_oe_n_r <= drq_oe_n_nxt;
            dack_r <= dack_nxt;
        end
    end

    // ----------------------------------------------------------------
    // read sequencing and two-entry read buffer
    // ----------------------------------------------------------------
    logic out_v_r, out_v_nxt, skid_v_r, skid_v_nxt;
    logic [7:0] out_d_r, out_d_nxt, skid_d_r, skid_d_nxt;
    logic ready_r, ready_nxt, rdy_r, rdy_nxt;

    always_comb
    begin
        state_nxt = state_r;
        held_nxt = held_r;
        push = 1'b0;
        case (state_r)
            ECP_ST_IDLE:
            begin
                if (acc_rd)
                begin
                    if (host_req.addr == `ECP_OFS_ECR && fifo_stat.stale)
                    begin
                        state_nxt = ECP_ST_WAIT;
                        held_nxt = host_req;
                    end
                    else
                        push = 1'b1;
                end
            end
            ECP_ST_WAIT:
            begin
                if (!fifo_stat.stale)
                begin
                    push = 1'b1;
                    state_nxt = ECP_ST_IDLE;
                end
            end
            default:
                state_nxt = ECP_ST_IDLE;
        endcase
        out_v_nxt = out_v_r;
        out_d_nxt = out_d_r;
        skid_v_nxt = skid_v_r;
        skid_d_nxt = skid_d_r;
        // drain first, so a skid word moves up
        if (out_v_r && rd_ready)
        begin
            if (skid_v_r)
            begin
                out_d_nxt = skid_d_r;
                skid_v_nxt = 1'b0;
            end
            else
                out_v_nxt = 1'b0;
        end
        if (push)
        begin
            if (!out_v_nxt)
            begin
                out_v_nxt = 1'b1;
                out_d_nxt = rdata_comb;
            end
            else
            begin
                skid_v_nxt = 1'b1;
                skid_d_nxt = rdata_comb;
            end
        end
        ready_nxt = (state_nxt == ECP_ST_IDLE) & ~(out_v_nxt & skid_v_nxt);
        // ready line low while the read is stretched
        rdy_nxt = (state_nxt == ECP_ST_IDLE);
    end

    // register stage for the read path
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            state_r <= ECP_ST_IDLE;
            held_r <= '0;
            out_v_r <= 1'b0;
            out_d_r <= 8'h00;
            skid_v_r <= 1'b0;
            skid_d_r <= 8'h00;
            ready_r <= 1'b1;
            rdy_r <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            held_r <= held_nxt;
            out_v_r <= out_v_nxt;
            out_d_r <= out_d_nxt;
            skid_v_r <= skid_v_nxt;
            skid_d_r <= skid_d_nxt;
            ready_r <= ready_nxt;
            rdy_r <= rdy_nxt;
        end
    end

    assign host_ready = ready_r;
    assign iochrdy = rdy_r;
    assign rd_valid = out_v_r;
    assign rd_data = out_d_r;
    assign irq_pulse = irq_r;
    assign mode = ecr_r[7:5];
    assign dma_enable = ecr_r[`ECP_ECR_DMA];
    assign drq_out = drq_r;
    assign drq_oe_n = drq_oe_n_r;
    assign dack_active = dack_r;
    assign freeze = freeze_r;
    assign freeze_init = finit_r;
    assign control2 = ctl2_r;
    assign control4 = ctl4_r;
    assign port_dma_irq_setup = setup_r;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_armed_tc;
        !ecr_r[`ECP_ECR_SVC] && ecr_r[`ECP_ECR_DMA] && tc_rise;
    endsequence
    sequence s_irq_and_set;
        irq_pulse && ecr_r[`ECP_ECR_SVC];
    endsequence

    a_reset_ecr_value: assert property (@(posedge mclk) $fell(reset) |-> ecr_r == 8'h15)
        else $error("extended control reset value wrong");
    a_tc_sets_service: assert property (@(posedge mclk) disable iff (reset) s_armed_tc |=> s_irq_and_set)
        else $error("terminal count did not interrupt");
    a_service_blocks_drq: assert property (@(posedge mclk) disable iff (reset) ecr_r[`ECP_ECR_SVC] |-> !drq_out)
        else $error("dma request while service set");
    a_dma_off_float: assert property (@(posedge mclk) disable iff (reset)
        !ecr_r[`ECP_ECR_DMA] |-> drq_oe_n && !dack_active)
        else $error("dma pins active while disabled");
    a_stale_holds_ready: assert property (@(posedge mclk) disable iff (reset)
        (state_r == ECP_ST_WAIT && fifo_stat.stale) |-> !iochrdy)
        else $error("ready high during stale read");
    a_frozen_flags_read: assert property (@(posedge mclk) disable iff (reset)
        (cur.addr == `ECP_OFS_ECR && clk_frozen) |-> rdata_comb[2:0] == 3'h3)
        else $error("frozen flags read wrong");
    a_err_edge_irq: assert property (@(posedge mclk) disable iff (reset)
        (!ecr_r[`ECP_ECR_MASK] && !ecr_nxt[`ECP_ECR_MASK] && $fell(err_n_s)) |=> irq_pulse)
        else $error("error edge missed");
    a_cfgb_mirror: assert property (@(posedge mclk) disable iff (reset)
        (cur.addr == `ECP_OFS_CFGB && ecr_r[7:5] == 3'h7)
        |-> !rdata_comb[7] && !rdata_comb[2] && rdata_comb[5:3] == port_dma_irq_setup[5:3]
        && rdata_comb[1:0] == port_dma_irq_setup[1:0])
        else $error("mirror contents wrong");
    a_idx_upper_zero: assert property (@(posedge mclk) disable iff (reset)
        (cur.addr == `ECP_OFS_IDX) |-> rdata_comb[7:3] == 5'h00)
        else $error("index upper bits nonzero");
    a_freeze_release: assert property (@(posedge mclk) disable iff (reset)
        ($fell(ctl0_r[`ECP_C0_FREEZE]) && $past(ecr_r[7:5]) == 3'h3) |-> freeze_init)
        else $error("freeze release without init pulse");
endmodule // ecp_ext_regs
`default_nettype wire

// >>> tb/ecp_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module ecp_far_model (
    input wire logic mclk,
    input wire logic hold,
    input wire logic tc_fire,
    input wire logic err_on,
    output logic rd_ready,
    output logic tc_pin,
    output logic err_n_pin
);
    logic rdy_r = 1'b0;
    logic [2:0] tc_cnt_r = 3'h0;
    // ------------------------------------------------
    // host side: read consumer and bus pins
    // ------------------------------------------------
    // consumer takes words at random, stalls while held
    always_ff @(posedge mclk)
    begin
        rdy_r <= hold ? 1'b0 : 1'($urandom_range(0, 1));
    end
    assign rd_ready = rdy_r;
    // terminal count pulse
    // terminal count stands high four cycles per request
    always_ff @(posedge mclk)
    begin
        if (tc_fire)
            tc_cnt_r <= 3'h4;
        else if (tc_cnt_r != 3'h0)
            tc_cnt_r <= tc_cnt_r - 3'h1;
    end
    assign tc_pin = (tc_cnt_r != 3'h0);
    assign err_n_pin = ~err_on;
endmodule // ecp_far_model
`default_nettype wire

// >>> tb/ecp_ext_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ecp_ext_regs_tb_top;
    import ecp_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    ecp_host_req_s host_req = '0;
    ecp_fifo_stat_s fifo_stat = '{1'b1, 1'b0, 5'h00, 5'h00, 1'b0, 1'b0};
    logic clk_frozen = 1'b0, line_dir = 1'b0, ext_enable = 1'b1, irq_line_pin = 1'b1;
    logic hold = 1'b0, tc_fire = 1'b0, err_on = 1'b0;
    logic dma_req = 1'b0, epp_to = 1'b0, dack_n = 1'b1;
    logic host_ready, iochrdy, rd_valid, rd_ready, tc_pin, err_n_pin, irq_pulse;
    logic dma_enable, drq_out, drq_oe_n, dack_active, freeze, freeze_init;
    logic [7:0] rd_data, control2, control4, port_dma_irq_setup, m_ecr, d, exp_w;
    logic [7:0] m_sl [0:7];
    logic [2:0] mode, m_idx;
    logic [7:0] exp_q [$];
    int num_errors = 0, total_checks = 0, irq_cnt = 0, fi_cnt = 0, cyc = 0;

    ecp_ext_regs DUT (.mclk(mclk), .reset(reset), .host_req(host_req), .host_ready(host_ready),
        .iochrdy(iochrdy), .rd_valid(rd_valid), .rd_data(rd_data), .rd_ready(rd_ready),
        .fifo_stat(fifo_stat), .clk_frozen(clk_frozen), .line_dir(line_dir), .ext_enable(ext_enable),
        .dma_req_in(dma_req), .epp_timeout(epp_to), .err_n_pin(err_n_pin), .irq_line_pin(irq_line_pin),
        .tc_pin(tc_pin), .dack_n_pin(dack_n), .irq_pulse(irq_pulse), .mode(mode), .dma_enable(dma_enable),
        .drq_out(drq_out), .drq_oe_n(drq_oe_n), .dack_active(dack_active), .freeze(freeze),
        .freeze_init(freeze_init), .control2(control2), .control4(control4),
        .port_dma_irq_setup(port_dma_irq_setup));
    ecp_far_model FAR (.mclk(mclk), .hold(hold), .tc_fire(tc_fire), .err_on(err_on),
        .rd_ready(rd_ready), .tc_pin(tc_pin), .err_n_pin(err_n_pin));

    // ------------------------------------------------
    // clock, timeout and report
    // ------------------------------------------------
    initial
    begin
        forever #2 mclk = ~mclk;
    end
    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // hang guard, then event counters and read-data scoreboard
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            close_out();
        end
        if (irq_pulse === 1'b1) irq_cnt++;
        if (freeze_init === 1'b1) fi_cnt++;
        if (rd_valid === 1'b1 && rd_ready === 1'b1)
        begin
            exp_w = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
            chk(rd_data, exp_w);
        end
    end

    // ------------------------------------------------
    // behavioural register model and bus tasks
    // ------------------------------------------------
    function automatic logic [7:0] expv(input logic [10:0] a);
        logic ok;
        ok = ext_enable && (m_idx inside {3'h0, 3'h2, 3'h4, 3'h5});
        case (a)
            11'h401: return (m_ecr[7:5] == 3'h7) ? {1'b0, irq_line_pin, m_sl[5][5:3], 1'b0, m_sl[5][1:0]} : 8'h00;
            11'h402: return {m_ecr[7:3], m_ecr[2] & ~clk_frozen, fifo_stat.full | clk_frozen,
                fifo_stat.empty | clk_frozen};
            11'h403: return ext_enable ? {5'h00, m_idx} : 8'h00;
            11'h404: return ok ? m_sl[m_idx] : 8'h00;
            11'h405: return (m_ecr[7:5] == 3'h3 && line_dir) ? {fifo_stat.bottom_tag, 7'h00} : 8'h00;
            default: return 8'h00;
        endcase
    endfunction
    task automatic bus(input logic r, input logic w, input logic [10:0] a, input logic [7:0] dv);
        @(posedge mclk);
        host_req <= '{r, w, a, dv};
        do @(posedge mclk); while (host_ready !== 1'b1);
        host_req <= '0;
    endtask
    task automatic wr(input logic [10:0] a, input logic [7:0] dv);
        bus(1'b0, 1'b1, a, dv);
        if (a == 11'h402) m_ecr = {dv[7:2], 2'b00};
        else if (a == 11'h403 && ext_enable) m_idx = dv[2:0];
        else if (a == 11'h404 && ext_enable && (m_idx inside {3'h0, 3'h2, 3'h4, 3'h5})) m_sl[m_idx] = dv;
    endtask
    task automatic rd(input logic [10:0] a);
        bus(1'b1, 1'b0, a, 8'h00);
        exp_q.push_back(expv(a));
    endtask
    task automatic wait_cnt(ref int c, input int t);
        repeat (8) if (c < t) @(posedge mclk);
        chk(8'(c), 8'(t));
    endtask
    task automatic settle();
        repeat (200) if (exp_q.size() > 0) @(posedge mclk);
        repeat (3) @(posedge mclk);
    endtask

    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial
    begin
        void'($urandom(32'h3668bd40));
        m_ecr = 8'h14;
        m_idx = 3'h0;
        m_sl = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00, 8'h00};
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        rd(11'h402);
        for (int i = 0; i < 8; i += 2) begin wr(11'h403, 8'(i)); rd(11'h404); end
        chk(8'(drq_oe_n), 8'h01);
        for (int m = 0; m < 8; m++)
        begin
            wr(11'h402, {3'(m), 5'h17});
            repeat (2) @(posedge mclk);
            chk(8'(mode), 8'(m));
            rd(11'h402);
        end
        d = 8'($urandom());
        wr(11'h403, 8'h05);
        wr(11'h404, d);
        wr(11'h401, 8'hFF);
        repeat (2) @(posedge mclk);
        chk(port_dma_irq_setup, d);
        rd(11'h401);
        irq_line_pin <= 1'b0;
        repeat (4) @(posedge mclk);
        rd(11'h401);
        rd(11'h401);
        wr(11'h403, 8'hFA);
        rd(11'h403);
        wr(11'h404, 8'($urandom()));
        repeat (2) @(posedge mclk);
        chk(control2, m_sl[2]);
        wr(11'h403, 8'h01);
        wr(11'h404, 8'h55);
        rd(11'h404);
        ext_enable <= 1'b0;
        wr(11'h403, 8'h04);
        rd(11'h403);
        ext_enable <= 1'b1;
        rd(11'h403);
        settle();
        // stretch a status read, then fill the two-word buffer
        fifo_stat.stale <= 1'b1;
        rd(11'h402);
        repeat (2) @(posedge mclk);
        chk({6'h00, iochrdy, host_ready}, 8'h00);
        fifo_stat.stale <= 1'b0;
        settle();
        hold <= 1'b1;
        rd(11'h402);
        rd(11'h405);
        repeat (2) @(posedge mclk);
        chk(8'(host_ready), 8'h00);
        hold <= 1'b0;
        fifo_stat.full <= 1'b1;
        clk_frozen <= 1'b1;
        settle();
        rd(11'h402);
        settle();
        clk_frozen <= 1'b0;
        fifo_stat.full <= 1'b0;
        // mode 011: tag, freeze and interrupt events
        wr(11'h402, 8'h74);
        @(posedge mclk) epp_to <= 1'b1;
        @(posedge mclk) epp_to <= 1'b0;
        line_dir <= 1'b1;
        fifo_stat.bottom_tag <= 1'b1;
        wr(11'h403, 8'h00);
        wr(11'h404, 8'h11);
        repeat (3) @(posedge mclk);
        chk(8'(freeze), 8'h01);
        rd(11'h405);
        wr(11'h404, 8'h01);
        wait_cnt(fi_cnt, 1);
        @(posedge mclk) epp_to <= 1'b1;
        @(posedge mclk) epp_to <= 1'b0;
        wait_cnt(irq_cnt, 1);
        line_dir <= 1'b0;
        dma_req <= 1'b1;
        dack_n <= 1'b0;
        wr(11'h402, 8'h78);
        repeat (2) @(posedge mclk);
        chk(8'(drq_oe_n), 8'h00);
        chk(8'(drq_out), 8'h01);
        chk(8'(dack_active), 8'h01);
        @(posedge mclk) tc_fire <= 1'b1;
        @(posedge mclk) tc_fire <= 1'b0;
        wait_cnt(irq_cnt, 2);
        chk(8'(drq_out), 8'h00);
        m_ecr[2] = 1'b1;
        rd(11'h402);
        wr(11'h402, 8'h70);
        fifo_stat.free_cnt <= 5'h08;
        wait_cnt(irq_cnt, 3);
        chk(8'(dack_active), 8'h00);
        m_ecr[2] = 1'b1;
        rd(11'h402);
        fifo_stat.free_cnt <= 5'h00;
        line_dir <= 1'b1;
        fifo_stat.fill_cnt <= 5'h08;
        wr(11'h402, 8'h70);
        wait_cnt(irq_cnt, 4);
        m_ecr[2] = 1'b1;
        fifo_stat.fill_cnt <= 5'h00;
        wr(11'h402, 8'h64);
        err_on <= 1'b1;
        wait_cnt(irq_cnt, 5);
        wr(11'h402, 8'h74);
        wr(11'h402, 8'h64);
        wait_cnt(irq_cnt, 6);
        err_on <= 1'b0;
        rd(11'h402);
        settle();
        close_out();
    end
endmodule // ecp_ext_regs_tb_top
`default_nettype wire
